// [core/bfd_flashover_core.sv]
// breaker flashover detector with apb settings and status
//
// Contract
// R01: one or two voltage sets; second side none means single set
// R02: single set arms on live voltage, breaker open, no current
// R03: single set ignores voltage difference when arming
// R04: single set picks up on open, voltage below pickup, current above
// R05: reset on current gone, breaker closed or supervision high
// R06: two sets arm on difference above, one voltage live, no current
// R07: two sets pick up on both sides low, difference low, current
// R08: pickup drives pickup outputs and starts 0 to 65.535 s ms timer
// R09: two sets may run without breaker status, status optional
// R10: live voltage on either or both sides arms the detector
// R11: voltage pickup 0 to 1.500 pu in 0.001 steps
// R12: difference pickup 0 to 100000 primary volts in 1 V steps
// R13: current pickup 0 to 1.500 pu in 0.001 steps
// R14: breaker open status taken per pole, detection per pole
// R15: per pole supervision operand governs that pole
// R16: supervision effect lasts 6 power cycles after it resets
// R17: only operates with phase to ground voltages connected
// R18: element disabled unless enable setting set, default disabled
// R19: operate only after pickup persists for the pickup delay
// R20: block input clears pickup, operate and the delay timer
// R21: target self reset, latched until cleared, or disabled
//
// Register access over APB and the register addresses were left to the implementer.
`include "bfd_defines.svh"
`timescale 1ns/10ps
module bfd_flashover_core #(
    parameter int unsigned MS_CYCLES = `BFD_MS_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [7:0]               paddr_i,
    input  wire logic [31:0]              pwdata_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    output logic                          pslverr_o,
    input  wire logic                     pass_i,
    input  wire bfd_pkg::bfd_phase_pu_t   measurement_source_one_volt_i,
    input  wire bfd_pkg::bfd_phase_pu_t   measurement_source_two_volt_i,
    input  wire bfd_pkg::bfd_phase_pu_t   measurement_source_one_amp_i,
    input  wire bfd_pkg::bfd_phase_pu_t   measurement_source_two_amp_i,
    input  wire bfd_pkg::bfd_phase_volt_t diff_volt_i,
    input  wire logic [2:0]               pole_open_i,
    input  wire logic [2:0]               pole_supervision_i,
    input  wire logic                     block_input_i,
    output logic      [2:0]               pickup_o,
    output logic                          pickup_any_o,
    output logic                          operate_o,
    output logic                          target_o,
    output logic                          event_o
);
    import bfd_pkg::*;

    logic [1:0]                rst_sync_r;
    logic                      rst_n;
    logic [`BFD_CTRL_W-1:0]    ctrl_r;
    bfd_pu_t                   vpkp_r;
    logic [16:0]               dvpkp_r;
    bfd_pu_t                   ipkp_r;
    logic [15:0]               delay_r;
    logic                      wr_en;
    logic                      rd_en;
    logic                      hit;
    logic                      tgt_clr;
    logic [31:0]               rd_val;
    logic                      enable;
    logic                      two_set;
    logic                      use_status;
    logic                      wye;
    bfd_target_e               tgt_mode;
    bfd_side2_e                side2;
    bfd_phase_pu_t             v1;
    bfd_phase_pu_t             v2;
    bfd_phase_pu_t             amp;
    logic [2:0]                spv_eff;
    logic [2:0][5:0]           spv_cnt_r;
    logic [2:0]                armed_r;
    logic [2:0]                pkp_r;
    logic [2:0]                arm_cond;
    logic [2:0]                pick_cond;
    logic [2:0]                rst_cond;
    logic                      run;
    logic                      pkp_any;
    logic [31:0]               ms_pre_r;
    logic [15:0]               elapsed_r;
    logic                      op_r;
    logic                      tgt_r;
    logic                      op_d_r;

    // above threshold test, per unit values; at-or-below is its negation
    function automatic logic above(input bfd_pu_t val, input bfd_pu_t thr);
        above = (val > thr);
    endfunction

    // clamp a per unit setting to its top of range
    function automatic bfd_pu_t clamp_pu(input logic [31:0] wd,
                                         input bfd_pu_t mx);
        clamp_pu = (wd > {16'h0000, mx}) ? mx : wd[15:0];
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // apb decode, zero wait state
    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign rd_en     = psel_i && !penable_i && !pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign tgt_clr   = wr_en && (paddr_i == `BFD_TGTCLR_OFS) && pwdata_i[0];

    // address decode and read mux
    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr_i == `BFD_CTRL_OFS) begin
            rd_val[`BFD_CTRL_W-1:0] = ctrl_r;
        end else if (paddr_i == `BFD_VPKP_OFS) begin
            rd_val[15:0] = vpkp_r;
        end else if (paddr_i == `BFD_DVPKP_OFS) begin
            rd_val[16:0] = dvpkp_r;
        end else if (paddr_i == `BFD_IPKP_OFS) begin
            rd_val[15:0] = ipkp_r;
        end else if (paddr_i == `BFD_DELAY_OFS) begin
            rd_val[15:0] = delay_r;
        end else if (paddr_i == `BFD_STATUS_OFS) begin
            // target, operate, armed, pickup and any pickup, low two zero
            rd_val[10:0] = {tgt_r, op_r, armed_r, pkp_r, pkp_any, 2'h0};
            rd_val[31:16] = elapsed_r;
        end else if (paddr_i == `BFD_TGTCLR_OFS) begin
            rd_val = 32'h0000_0000;
        end else begin
            hit = 1'b0;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_o <= rd_val;
        end
    end

    // settings registers, clamped to their ranges
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `BFD_CTRL_RST;                          // see R18
            vpkp_r  <= `BFD_VPKP_RST;
            dvpkp_r <= `BFD_DVPKP_RST;
            ipkp_r  <= `BFD_IPKP_RST;
            delay_r <= `BFD_DELAY_RST;
        end else if (wr_en) begin
            if (paddr_i == `BFD_CTRL_OFS) begin
                ctrl_r <= pwdata_i[`BFD_CTRL_W-1:0];
            end else if (paddr_i == `BFD_VPKP_OFS) begin
                vpkp_r <= clamp_pu(pwdata_i, `BFD_VPKP_MAX);   // see R11
            end else if (paddr_i == `BFD_DVPKP_OFS) begin
                dvpkp_r <= (pwdata_i > {15'h0000, `BFD_DVPKP_MAX}) ?
                           `BFD_DVPKP_MAX : pwdata_i[16:0];    // see R12
            end else if (paddr_i == `BFD_IPKP_OFS) begin
                ipkp_r <= clamp_pu(pwdata_i, `BFD_IPKP_MAX);   // see R13
            end else if (paddr_i == `BFD_DELAY_OFS) begin
                delay_r <= pwdata_i[15:0];                     // see R08
            end
        end
    end

    // control fields
    assign enable     = ctrl_r[`BFD_CTRL_EN_BIT];
    assign side2      = bfd_side2_e'(ctrl_r[`BFD_CTRL_SIDE2_LSB +: 2]);
    assign two_set    = (side2 != BFD_SIDE2_NONE);             // see R01
    assign tgt_mode   = bfd_target_e'(ctrl_r[`BFD_CTRL_TGT_LSB +: 2]);
    assign use_status = ctrl_r[`BFD_CTRL_USEST_BIT] || !two_set; // see R09
    assign wye        = ctrl_r[`BFD_CTRL_WYE_BIT];
    assign run        = enable && wye;                         // see R17

    // source selection for both sides
    assign v1  = ctrl_r[`BFD_CTRL_SIDE1_BIT] ? measurement_source_two_volt_i : measurement_source_one_volt_i;
    assign amp = ctrl_r[`BFD_CTRL_SIDE1_BIT] ? measurement_source_two_amp_i : measurement_source_one_amp_i;
    assign v2  = (side2 == BFD_SIDE2_MEASUREMENT_SOURCE_TWO) ? measurement_source_two_volt_i : measurement_source_one_volt_i;

    // supervision hold, reloaded while high, counts passes after release
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            spv_cnt_r <= '0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (pole_supervision_i[p]) begin
                    spv_cnt_r[p] <= `BFD_SPV_PASSES;           // see R16
                end else if (pass_i && spv_cnt_r[p] != 6'h00) begin
                    spv_cnt_r[p] <= spv_cnt_r[p] - 6'h01;
                end
            end
        end
    end

    // per pole arm, pickup and reset terms
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            spv_eff[p] = pole_supervision_i[p] ||
                         (spv_cnt_r[p] != 6'h00);              // see R15
            if (two_set) begin
                arm_cond[p] = (diff_volt_i[p] > dvpkp_r) &&
                              (above(v1[p], vpkp_r) ||
                               above(v2[p], vpkp_r)) &&       // see R10
                              !above(amp[p], ipkp_r);          // see R06
                pick_cond[p] = !above(v1[p], vpkp_r) &&
                               !above(v2[p], vpkp_r) &&
                               (diff_volt_i[p] < dvpkp_r) &&
                               above(amp[p], ipkp_r);          // see R07
            end else begin
                arm_cond[p] = above(v1[p], vpkp_r) &&
                              !above(amp[p], ipkp_r);      // see R02 R03
                pick_cond[p] = !above(v1[p], vpkp_r) &&
                               above(amp[p], ipkp_r);          // see R04
            end
            arm_cond[p]  = arm_cond[p] &&
                           (pole_open_i[p] || !use_status);    // see R14
            pick_cond[p] = pick_cond[p] &&
                           (pole_open_i[p] || !use_status);
            rst_cond[p]  = spv_eff[p] ||
                           (use_status && !pole_open_i[p]);    // see R05
        end
    end

    // arm and pickup state, evaluated once per protection pass
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= 3'h0;
            pkp_r   <= 3'h0;
        end else if (!run) begin
            armed_r <= 3'h0;                                   // see R18
            pkp_r   <= 3'h0;
        end else if (pass_i) begin
            for (int p = 0; p < 3; p++) begin
                if (rst_cond[p]) begin
                    armed_r[p] <= 1'b0;
                    pkp_r[p]   <= 1'b0;
                end else if (pkp_r[p]) begin
                    pkp_r[p] <= above(amp[p], ipkp_r);         // see R05
                end else if (armed_r[p] && pick_cond[p]) begin
                    pkp_r[p] <= 1'b1;
                end else if (arm_cond[p]) begin
                    armed_r[p] <= 1'b1;
                end
            end
        end
    end

    assign pkp_any = (|pkp_r) && !block_input_i;

    // pickup delay timer in milliseconds
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ms_pre_r  <= 32'h0000_0000;
            elapsed_r <= 16'h0000;
        end else if (!pkp_any) begin
            ms_pre_r  <= 32'h0000_0000;                        // see R20
            elapsed_r <= 16'h0000;
        end else if (ms_pre_r == MS_CYCLES - 1) begin
            ms_pre_r <= 32'h0000_0000;
            if (elapsed_r != 16'hFFFF) begin
                elapsed_r <= elapsed_r + 16'h0001;             // see R08
            end
        end else begin
            ms_pre_r <= ms_pre_r + 32'h0000_0001;
        end
    end

    // registered outputs, block forces them inactive
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pickup_o     <= 3'h0;
            pickup_any_o <= 1'b0;
            op_r         <= 1'b0;
        end else begin
            pickup_o     <= block_input_i ? 3'h0 : pkp_r;      // see R20
            pickup_any_o <= pkp_any;
            op_r         <= pkp_any && (elapsed_r >= delay_r); // see R19
        end
    end
    assign operate_o = op_r;

    // target indication; a new operate wins over a clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tgt_r <= 1'b0;
        end else begin
            case (tgt_mode)
                BFD_TGT_SELF: begin
                    tgt_r <= op_r;                             // see R21
                end
                BFD_TGT_LATCH: begin
                    if (op_r) begin
                        tgt_r <= 1'b1;
                    end else if (tgt_clr) begin
                        tgt_r <= 1'b0;
                    end
                end
                default: begin
                    tgt_r <= 1'b0;
                end
            endcase
        end
    end
    assign target_o = tgt_r;

    // event pulse on pickup or operate rising edge; operate keeps its own
    // delayed copy so a delayed operate still gives a pulse of its own
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            op_d_r  <= 1'b0;
            event_o <= 1'b0;
        end else begin
            op_d_r  <= op_r;
            event_o <= ctrl_r[`BFD_CTRL_EVT_BIT] &&
                       ((pkp_any && !pickup_any_o) || (op_r && !op_d_r));
        end
    end

    // bus phases
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence

    // unmapped access answers with an error in its access phase
    AST_APB_ERR: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_setup ##1 (s_access and (!hit)) |-> pslverr_o && pready_o)
        else $error("unmapped access not flagged");
    AST_DISABLED: assert property (@(posedge clk_i) disable iff (!rst_n)
        !enable |=> (pkp_r == 3'h0) && (armed_r == 3'h0)) // see R18
        else $error("disabled element holds state");
    AST_DELTA: assert property (@(posedge clk_i) disable iff (!rst_n)
        !wye |=> ##1 !op_r && (pickup_o == 3'h0))          // see R17
        else $error("element active with delta voltages");
    AST_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n)
        block_input_i |=> !op_r && pickup_o == 3'h0 &&
                          elapsed_r == 16'h0000)           // see R20
        else $error("block did not clear outputs");
    AST_OP_DELAY: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(op_r) |-> $past(elapsed_r) >= delay_r && $past(pkp_any))
        else $error("operate before pickup delay");         // see R19
    AST_SPV_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
        $fell(pole_supervision_i[0]) |-> spv_cnt_r[0] == `BFD_SPV_PASSES)
        else $error("supervision hold not loaded");        // see R16
    AST_CLOSE_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
        pass_i && use_status && !pole_open_i[0] |=> !pkp_r[0] && !armed_r[0])
        else $error("closed breaker kept detection");      // see R05
    AST_SINGLE_ARM: assert property (@(posedge clk_i) disable iff (!rst_n)
        pass_i && run && !two_set && pole_open_i[0] && !spv_eff[0] &&
        !pkp_r[0] && above(v1[0], vpkp_r) && !above(amp[0], ipkp_r)
        |=> armed_r[0])                                    // see R02
        else $error("single set failed to arm");
    AST_LATCH: assert property (@(posedge clk_i) disable iff (!rst_n)
        tgt_mode == BFD_TGT_LATCH && tgt_r && !tgt_clr &&
        $stable(ctrl_r) |=> tgt_r)                         // see R21
        else $error("latched target dropped");
endmodule

// [core/bfd_defines.svh]
// register map, field positions, reset values and timing counts
`ifndef BFD_DEFINES_SVH
`define BFD_DEFINES_SVH

// register byte offsets
`define BFD_CTRL_OFS        8'h00
`define BFD_VPKP_OFS        8'h04
`define BFD_DVPKP_OFS       8'h08
`define BFD_IPKP_OFS        8'h0C
`define BFD_DELAY_OFS       8'h10
`define BFD_STATUS_OFS      8'h14
`define BFD_TGTCLR_OFS      8'h18

// control register fields
`define BFD_CTRL_EN_BIT     0
`define BFD_CTRL_SIDE1_BIT  1
`define BFD_CTRL_SIDE2_LSB  2
`define BFD_CTRL_TGT_LSB    4
`define BFD_CTRL_EVT_BIT    6
`define BFD_CTRL_USEST_BIT  7
`define BFD_CTRL_WYE_BIT    8
`define BFD_CTRL_W          9

// reset values and setting limits
`define BFD_CTRL_RST        9'h184
`define BFD_VPKP_RST        16'h0352
`define BFD_VPKP_MAX        16'h05DC
`define BFD_DVPKP_RST       17'h003E8
`define BFD_DVPKP_MAX       17'h186A0
`define BFD_IPKP_RST        16'h0258
`define BFD_IPKP_MAX        16'h05DC
`define BFD_DELAY_RST       16'h0064

// timing
`define BFD_CLK_NS          10
`define BFD_MS_NS           1000000
`define BFD_MS_CYCLES       (`BFD_MS_NS / `BFD_CLK_NS)
`define BFD_SPV_CYCLES      6
`define BFD_PASS_PER_CYCLE  8
`define BFD_SPV_PASSES      6'(`BFD_SPV_CYCLES * `BFD_PASS_PER_CYCLE)

`endif

// [core/bfd_pkg.sv]
// types shared by the breaker flashover detector
package bfd_pkg;
    typedef logic [15:0]       bfd_pu_t;
    typedef logic [2:0][15:0]  bfd_phase_pu_t;
    typedef logic [2:0][16:0]  bfd_phase_volt_t;
    typedef enum logic [1:0] {
        BFD_SIDE2_NONE,
        BFD_SIDE2_MEASUREMENT_SOURCE_ONE,
        BFD_SIDE2_MEASUREMENT_SOURCE_TWO
    } bfd_side2_e;
    typedef enum logic [1:0] {
        BFD_TGT_SELF,
        BFD_TGT_LATCH,
        BFD_TGT_OFF
    } bfd_target_e;
endpackage

// [tb/bfd_meas_model.sv]
// measurement source and breaker contact model, refreshed per pass
`timescale 1ns/10ps
module bfd_meas_model #(
    parameter int PASS_CLKS = 4
) (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic [15:0]       v1_i,
    input  wire logic [15:0]       v2_i,
    input  wire logic [15:0]       amp_i,
    input  wire logic [16:0]       dv_i,
    input  wire logic [2:0]        open_i,
    output logic                   pass_o,
    output bfd_pkg::bfd_phase_pu_t v1_o,
    output bfd_pkg::bfd_phase_pu_t v2_o,
    output bfd_pkg::bfd_phase_pu_t a1_o,
    output bfd_pkg::bfd_phase_pu_t a2_o,
    output bfd_pkg::bfd_phase_volt_t dv_o,
    output logic [2:0]             open_o
);
    import bfd_pkg::*;
    int cnt_r;
    // pass strobe, one clock in every PASS_CLKS
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= (cnt_r == PASS_CLKS - 1) ? 0 : cnt_r + 1;
        end
    end
    assign pass_o = (cnt_r == PASS_CLKS - 1);
    // new phasors stand one clock before each pass
    always_ff @(posedge clk_i) begin
        if (cnt_r == PASS_CLKS - 2) begin
            v1_o   <= {3{v1_i}}; // phase-ground set
            v2_o   <= {3{v2_i}};
            a1_o   <= {16'h0000, 16'h0000, amp_i}; // phase a only
            a2_o   <= '0;
            dv_o   <= {3{dv_i}};
            open_o <= open_i; // per pole status
        end
    end
endmodule

// [tb/breaker_flashover_detector_tb.sv]
// self-checking bench for the breaker flashover detector
`include "bfd_defines.svh"
`timescale 1ns/10ps
module breaker_flashover_detector_tb;
    import bfd_pkg::*;
    localparam int MSC = 10;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pass, pready, pslverr, pany, op, tgt, evt;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [15:0] mv1 = '0, mv2 = '0, mamp = '0;
    logic [16:0] mdv = '0;
    logic [2:0] mopen = '0, spv = '0, opn, pickup;
    logic blk = 1'b0;
    bfd_phase_pu_t v1, v2, a1, a2;
    bfd_phase_volt_t dv;
    int n_errors = 0, check_count = 0, n_evt = 0;
    // clock and event pulse count
    always #5 clk = ~clk;
    always @(posedge clk) if (evt === 1'b1) n_evt <= n_evt + 1;
    bfd_meas_model u_src (.clk_i(clk), .reset_n_i(rst_n), .v1_i(mv1),
        .v2_i(mv2), .amp_i(mamp), .dv_i(mdv), .open_i(mopen),
        .pass_o(pass), .v1_o(v1), .v2_o(v2), .a1_o(a1), .a2_o(a2),
        .dv_o(dv), .open_o(opn));
    bfd_flashover_core #(.MS_CYCLES(MSC)) u_dut (.clk_i(clk),
        .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .pass_i(pass), .measurement_source_one_volt_i(v1), .measurement_source_two_volt_i(v2),
        .measurement_source_one_amp_i(a1), .measurement_source_two_amp_i(a2), .diff_volt_i(dv),
        .pole_open_i(opn), .pole_supervision_i(spv),
        .block_input_i(blk), .pickup_o(pickup), .pickup_any_o(pany),
        .operate_o(op), .target_o(tgt), .event_o(evt));
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %0t reg %h exp %h", $time, g, e);
            n_errors++;
        end
    endtask
    task automatic chk3(input logic [2:0] g, e);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %0t poles %b exp %b", $time, g, e);
            n_errors++;
        end
    endtask
    task automatic chk1(input logic g, e);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %0t flag %b exp %b", $time, g, e);
            n_errors++;
        end
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            $display("[FAIL] %0t no pready", $time);
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? pany : (s == 1 ? op : tgt);
    endfunction
    task automatic watch(input int s, input logic v, input int lim,
                         output int n);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (sig(s) !== v) begin
            $display("[FAIL] %0t wait ran out", $time);
            n_errors++;
            end_of_test();
        end
    endtask
    task automatic quiet(input int s, input int lim);
        logic bad;
        bad = 1'b0;
        repeat (lim) begin
            @(posedge clk);
            if (sig(s) === 1'b1) bad = 1'b1;
        end
        chk1(bad, 1'b0);
    endtask
    // arm with live voltage and no current, then collapse with current
    task automatic run(input logic [15:0] v2a, input logic [16:0] da,
                       df, input logic [2:0] po, input logic ex);
        int n;
        @(posedge clk);
        mv1 <= 16'h03E8;
        mv2 <= v2a;
        mamp <= 16'h0000;
        mdv <= da;
        mopen <= po;
        repeat (16) @(posedge clk);
        mv1 <= 16'h0064;
        mv2 <= 16'h0064;
        mamp <= 16'h0320;
        mdv <= df;
        if (ex) begin
            watch(0, 1'b1, 16, n);
            chk3(pickup, 3'b001);
        end else begin
            quiet(0, 48);
        end
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        logic [7:0] ad [5] = '{`BFD_CTRL_OFS, `BFD_VPKP_OFS,
            `BFD_DVPKP_OFS, `BFD_IPKP_OFS, `BFD_DELAY_OFS};
        logic [31:0] rv [5] = '{32'(`BFD_CTRL_RST), 32'(`BFD_VPKP_RST),
            32'(`BFD_DVPKP_RST), 32'(`BFD_IPKP_RST), 32'(`BFD_DELAY_RST)};
        logic [31:0] mx [3] = '{32'(`BFD_VPKP_MAX), 32'(`BFD_DVPKP_MAX),
            32'(`BFD_IPKP_MAX)};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ad[i], '0, r, e);
            chk32(r, rv[i]);
        end
        apb(1'b0, 8'h1C, '0, r, e);
        chk1(e, 1'b1);
        for (int i = 1; i < 4; i++) begin
            wr(ad[i], 32'hFFFFFFFF);
            apb(1'b0, ad[i], '0, r, e);
            chk32(r, mx[i-1]);
            wr(ad[i], rv[i]);
        end
    endtask
    task automatic t_single;
        int n, e0;
        logic [31:0] r;
        logic e;
        wr(`BFD_CTRL_OFS, 32'h000001D1);
        wr(`BFD_DELAY_OFS, 32'h00000002);
        e0 = n_evt;
        run(16'h0000, '0, '0, 3'b111, 1'b1);
        watch(1, 1'b1, 40, n);
        chk1(n >= 2 * MSC - 2 && n <= 2 * MSC + 2, 1'b1);
        apb(1'b0, `BFD_STATUS_OFS, '0, r, e);
        chk32(r & 32'h0000_07FC, 32'h0000_07CC);
        mamp <= 16'h0000;
        watch(0, 1'b0, 16, n);
        watch(1, 1'b0, 4, n);
        chk1(tgt, 1'b1);
        chk32(32'(n_evt - e0), 32'h2);
        wr(`BFD_TGTCLR_OFS, 32'h00000001);
        watch(2, 1'b0, 4, n);
    endtask
    task automatic t_close_block;
        int n;
        run(16'h0000, '0, '0, 3'b111, 1'b1);
        mopen <= 3'b000;
        watch(0, 1'b0, 16, n);
        run(16'h0000, '0, '0, 3'b111, 1'b1);
        blk <= 1'b1;
        watch(0, 1'b0, 3, n);
        quiet(1, 30);
        blk <= 1'b0;
    endtask
    task automatic t_spv;
        spv <= 3'b001;
        run(16'h0000, '0, '0, 3'b111, 1'b0);
        spv <= 3'b000;
        run(16'h0000, '0, '0, 3'b111, 1'b0);
        repeat (200) @(posedge clk);
        run(16'h0000, '0, '0, 3'b111, 1'b1);
    endtask
    task automatic t_two_set;
        wr(`BFD_CTRL_OFS, 32'h00000109);
        run(16'h0000, 17'h005DC, 17'h00064, 3'b000, 1'b1);
        run(16'h03E8, 17'h005DC, 17'h00064, 3'b000, 1'b1);
        // arming persists without status; disable once to start unarmed
        wr(`BFD_CTRL_OFS, 32'h00000108);
        wr(`BFD_CTRL_OFS, 32'h00000109);
        run(16'h0000, 17'h001F4, 17'h00064, 3'b000, 1'b0);
        wr(`BFD_CTRL_OFS, 32'h000000D1);
        run(16'h0000, '0, '0, 3'b111, 1'b0);
    endtask
    // reset, then each scenario in turn
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        run(16'h0000, '0, '0, 3'b111, 1'b0);
        t_single();
        t_close_block();
        t_spv();
        t_two_set();
        end_of_test();
    end
endmodule
